/* rtl/hcfb_pkg.sv */
/*
 * Shared constants for the host control flag register and byte-order steering.
 * Assumes a 32-bit classic Wishbone register bus with word addressing by byte address.
 */
package hcfb_pkg;
    // Register byte offsets
    localparam logic [7:0] HCFB_SET_OFS = 8'h50;
    localparam logic [7:0] HCFB_CLR_OFS = 8'h54;
    localparam logic [7:0] HCFB_STAT_OFS = 8'h58;
    // Flag bit positions
    localparam int HCFB_BIG_END_BIT = 30;
    localparam int HCFB_PERMIT_BIT = 23;
    localparam int HCFB_ENH_BIT = 22;
    localparam int HCFB_LPS_BIT = 19;
    localparam int HCFB_POST_BIT = 18;
    localparam int HCFB_ATTACH_BIT = 17;
    localparam int HCFB_SRST_BIT = 16;
    // Transaction codes
    localparam logic [3:0] HCFB_TC_QWR = 4'h0;
    localparam logic [3:0] HCFB_TC_BWR = 4'h1;
    localparam logic [3:0] HCFB_TC_QRSP = 4'h6;
    localparam logic [3:0] HCFB_TC_BRSP = 4'h7;
    localparam logic [3:0] HCFB_TC_STRM = 4'hA;
    localparam logic [3:0] HCFB_TC_LKREQ = 4'h9;
    localparam logic [3:0] HCFB_TC_LKRSP = 4'hB;
    localparam logic [3:0] HCFB_TC_PHY = 4'hE;
    // Soft reset duration
    localparam int HCFB_SRST_NS = 256;
    localparam int HCFB_CLK_NS = 8;
    localparam int HCFB_SRST_CYC = HCFB_SRST_NS / HCFB_CLK_NS;
    localparam logic [31:0] HCFB_ERR_DATA = 32'h0000_0000;
endpackage

/* rtl/hcfb_swap_if.sv */
/*
 * Carrier between the flag register and the byte-order steering unit.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface hcfb_swap_if;
    logic big_endian;
    logic [3:0] tcode;
    logic is_header;
    logic is_cycle_time;
    logic [31:0] din;
    logic [31:0] dout;
    modport ctrl (output big_endian, tcode, is_header, is_cycle_time, din, input dout);
    modport swap (input big_endian, tcode, is_header, is_cycle_time, din, output dout);
endinterface

/* rtl/hcfb_swap.sv */
/*
 * Byte-order steering of one quadlet of packet data.
 * Assumes the caller marks header quadlets and the internal cycle time value.
 */
`timescale 1ns/1ps
module hcfb_swap (
    // Steering carrier
    hcfb_swap_if.swap sw
);
    import hcfb_pkg::*;

    // Tcodes whose data quadlets follow the byte order selection
    function automatic logic hcfb_swappable(input logic [3:0] tc);
        hcfb_swappable = (tc == HCFB_TC_BWR) || (tc == HCFB_TC_BRSP) ||
            (tc == HCFB_TC_LKREQ) || (tc == HCFB_TC_STRM) ||
            (tc == HCFB_TC_LKRSP) || (tc == HCFB_TC_QWR) ||
            (tc == HCFB_TC_QRSP); // [R20] [R21]
    endfunction

    // Reverse bytes only for little-endian swappable data
    always_comb begin
        if (!sw.is_header && !sw.is_cycle_time && !sw.big_endian &&
                sw.tcode != HCFB_TC_PHY && hcfb_swappable(sw.tcode)) begin
            sw.dout = {sw.din[7:0], sw.din[15:8], sw.din[23:16], sw.din[31:24]}; // [R19]
        end else begin
            sw.dout = sw.din; // [R18] [R22] [R23]
        end
    end
endmodule

/* rtl/hcfb_top.sv */
/*
 * Host control flag register with set and clear ports, soft reset sequencing
 * and byte-order steering of packet data quadlets.
 * Assumes a classic Wishbone master and a synchronous, active high reset.
 */
// Contract
// [R1] Set and clear ports read flags; ones set or clear, zeros keep.
// [R2] Software sets enhancement only with permit high and attachment off.
// [R3] Enhancement flag one enables all enhancements; zero enables none.
// [R4] Enhancement flag hardware-resets to the implementation's default.
// [R5] Soft and bus resets leave the enhancement flag unchanged.
// [R6] Link power flag one permits link-to-PHY communication and requests.
// [R7] Link power off blocks PHY communication; other registers undefined.
// [R8] Link power flag resets to zero; writes only set it.
// [R9] Software never clears the link power flag.
// [R10] Posting flag one posts physical writes; zero answers ack pending.
// [R11] Software changes posting flag only while detached.
// [R12] Software sets attachment then forces a bus reset.
// [R13] Attachment off ignores PHY packets and makes no bus requests.
// [R14] Attachment flag resets to zero; software clear has no effect.
// [R15] Software sets attachment only after ROM mapping is valid.
// [R16] Soft reset restores controller registers and flushes all FIFOs.
// [R17] Soft reset flag reads one during any reset, zero otherwise.
// [R18] Header quadlets are never swapped.
// [R19] Selection clear sends data little endian; set sends big endian.
// [R20] Selection covers block data of tcodes 1, 7, 9, A and B.
// [R21] Selection covers quadlet write request and quadlet read response data.
// [R22] The cycle time value is never swapped.
// [R23] PHY packet data is never swapped.
`timescale 1ns/1ps
module hcfb_top #(
    parameter logic ENH_DEFAULT = 1'b0,
    parameter logic PERMIT_DEFAULT = 1'b1,
    parameter int SRST_CYCLES = hcfb_pkg::HCFB_SRST_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Link events
    input wire logic bus_reset_i,
    // Data path
    input wire logic [3:0] pkt_tcode_i,
    input wire logic pkt_header_i,
    input wire logic pkt_cycle_time_i,
    input wire logic [31:0] pkt_data_i,
    output logic [31:0] pkt_data_o,
    // Controller steering
    output logic phy_enhance_o,
    output logic phy_comm_on_o,
    output logic bus_attached_o,
    output logic write_posted_o,
    output logic fifo_flush_o,
    output logic controller_reset_o
);
    import hcfb_pkg::*;

    typedef enum logic [1:0] {HCFB_IDLE, HCFB_ACK} hcfb_bus_t;

    hcfb_bus_t bus_ff;
    logic enh_ff;
    logic permit_ff;
    logic lps_ff;
    logic post_ff;
    logic attach_ff;
    logic big_end_ff;
    logic [15:0] srst_cnt_ff;
    logic srst_busy_ff;
    logic [31:0] nxt_dat;
    logic wr_set;
    logic wr_clr;
    logic [31:0] wmask;
    logic [31:0] flags;
    logic soft_start;
    logic any_reset;
    hcfb_swap_if swp();

    // Byte lane mask from select lines
    always_comb begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end

    // Address decode
    always_comb begin
        wr_set = 1'b0;
        wr_clr = 1'b0;
        if (bus_ff == HCFB_IDLE && wb_cyc_i && wb_stb_i && wb_we_i) begin
            if (wb_adr_i == HCFB_SET_OFS) begin
                wr_set = 1'b1;
            end else if (wb_adr_i == HCFB_CLR_OFS) begin
                wr_clr = 1'b1;
            end
        end
    end

    // Soft reset request and global reset condition
    assign soft_start = wr_set && wmask[HCFB_SRST_BIT] && wb_dat_i[HCFB_SRST_BIT];
    assign any_reset = rst_i || srst_busy_ff;

    // Flag image seen on reads
    always_comb begin
        flags = 32'h0000_0000;
        flags[HCFB_BIG_END_BIT] = big_end_ff;
        flags[HCFB_PERMIT_BIT] = permit_ff;
        flags[HCFB_ENH_BIT] = enh_ff;
        flags[HCFB_LPS_BIT] = lps_ff;
        flags[HCFB_POST_BIT] = post_ff;
        flags[HCFB_ATTACH_BIT] = attach_ff;
        flags[HCFB_SRST_BIT] = srst_busy_ff; // [R17]
    end

    // Soft reset sequencer: busy while counting, also during hard reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srst_busy_ff <= 1'b1; // [R17]
            srst_cnt_ff <= 16'h0000;
        end else if (soft_start) begin
            srst_busy_ff <= 1'b1; // [R16]
            srst_cnt_ff <= 16'(SRST_CYCLES);
        end else if (srst_cnt_ff != 16'h0000) begin
            srst_cnt_ff <= srst_cnt_ff - 16'h0001;
        end else begin
            srst_busy_ff <= 1'b0; // [R17]
        end
    end

    // Enhancement flag: hardware reset only, kept over soft and bus reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enh_ff <= ENH_DEFAULT; // [R4]
        end else if (wr_set && wmask[HCFB_ENH_BIT] && wb_dat_i[HCFB_ENH_BIT]) begin
            enh_ff <= 1'b1; // [R1]
        end else if (wr_clr && wmask[HCFB_ENH_BIT] && wb_dat_i[HCFB_ENH_BIT]) begin
            enh_ff <= 1'b0; // [R1] [R5]
        end
    end

    // Permission flag: read and clear only, kept over soft reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            permit_ff <= PERMIT_DEFAULT;
        end else if (wr_clr && wmask[HCFB_PERMIT_BIT] && wb_dat_i[HCFB_PERMIT_BIT]) begin
            permit_ff <= 1'b0; // [R1]
        end
    end

    // Link power flag: set only by writes
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            lps_ff <= 1'b0; // [R8]
        end else if (wr_set && wmask[HCFB_LPS_BIT] && wb_dat_i[HCFB_LPS_BIT]) begin
            lps_ff <= 1'b1; // [R8]
        end
    end

    // Bus attachment flag: set only by writes, clear port ignored
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            attach_ff <= 1'b0; // [R14]
        end else if (wr_set && wmask[HCFB_ATTACH_BIT] && wb_dat_i[HCFB_ATTACH_BIT]) begin
            attach_ff <= 1'b1; // [R14]
        end
    end

    // Posting and byte-order flags, set/clear, cleared by hard and soft reset
    always_ff @(posedge clk_i) begin
        if (any_reset) begin
            post_ff <= 1'b0;
            big_end_ff <= 1'b0;
        end else begin
            if (wr_set && wmask[HCFB_POST_BIT] && wb_dat_i[HCFB_POST_BIT]) begin
                post_ff <= 1'b1; // [R1]
            end else if (wr_clr && wmask[HCFB_POST_BIT] && wb_dat_i[HCFB_POST_BIT]) begin
                post_ff <= 1'b0; // [R1]
            end
            if (wr_set && wmask[HCFB_BIG_END_BIT] && wb_dat_i[HCFB_BIG_END_BIT]) begin
                big_end_ff <= 1'b1; // [R1]
            end else if (wr_clr && wmask[HCFB_BIG_END_BIT] && wb_dat_i[HCFB_BIG_END_BIT]) begin
                big_end_ff <= 1'b0; // [R1]
            end
        end
    end

    // Read data and error selection
    always_comb begin
        nxt_dat = HCFB_ERR_DATA;
        if (wb_adr_i == HCFB_SET_OFS) begin
            nxt_dat = flags; // [R1]
        end else if (wb_adr_i == HCFB_CLR_OFS) begin
            nxt_dat = flags; // [R1]
        end else if (wb_adr_i == HCFB_STAT_OFS) begin
            nxt_dat = {28'h000_0000, bus_attached_o, phy_comm_on_o, write_posted_o,
                phy_enhance_o};
        end
    end

    // Decodes whether an access has a register behind it
    function automatic logic hcfb_mapped(input logic [7:0] adr, input logic we);
        hcfb_mapped = (adr == HCFB_SET_OFS) || (adr == HCFB_CLR_OFS) ||
            (adr == HCFB_STAT_OFS && !we);
    endfunction

    // Handshake state: marks the one cycle in which the answer stands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_ff <= HCFB_IDLE;
        end else if (bus_ff == HCFB_IDLE && wb_cyc_i && wb_stb_i) begin
            bus_ff <= HCFB_ACK;
        end else begin
            bus_ff <= HCFB_IDLE;
        end
    end

    // Acknowledge mapped accesses, error on unmapped ones and status writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else if (bus_ff == HCFB_IDLE && wb_cyc_i && wb_stb_i) begin
            wb_ack_o <= hcfb_mapped(wb_adr_i, wb_we_i); // [R1]
            wb_err_o <= !hcfb_mapped(wb_adr_i, wb_we_i);
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end
    end

    // Read data captured with the request; writes return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_ff == HCFB_IDLE && wb_cyc_i && wb_stb_i) begin
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : nxt_dat; // [R1]
        end
    end

    // Enhancement enable toward the PHY-link logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phy_enhance_o <= 1'b0;
        end else begin
            phy_enhance_o <= enh_ff; // [R3]
        end
    end

    // Link-to-PHY communication permit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phy_comm_on_o <= 1'b0;
        end else begin
            phy_comm_on_o <= lps_ff; // [R6] [R7]
        end
    end

    // Bus attachment, dropped while a bus reset is in progress
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_attached_o <= 1'b0;
        end else begin
            bus_attached_o <= attach_ff && !bus_reset_i; // [R13]
        end
    end

    // Posted physical writes; low means answer with ack pending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            write_posted_o <= 1'b0;
        end else begin
            write_posted_o <= post_ff; // [R10]
        end
    end

    // FIFO flush, raised already in the cycle after the soft reset request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fifo_flush_o <= 1'b1;
        end else begin
            fifo_flush_o <= srst_busy_ff || soft_start; // [R16]
        end
    end

    // Controller state reset, same span as the flush
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            controller_reset_o <= 1'b1;
        end else begin
            controller_reset_o <= srst_busy_ff || soft_start; // [R16]
        end
    end

    // Data path steering
    assign swp.big_endian = big_end_ff;
    assign swp.tcode = pkt_tcode_i;
    assign swp.is_header = pkt_header_i;
    assign swp.is_cycle_time = pkt_cycle_time_i;
    assign swp.din = pkt_data_i;

    hcfb_swap u_swap (
        .sw(swp)
    );

    // Registered steered quadlet
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pkt_data_o <= 32'h0000_0000;
        end else begin
            pkt_data_o <= swp.dout; // [R19]
        end
    end
endmodule

/* verification/hcfb_top_props.sv */
/* Checker for hcfb_top: bus answers, sticky flags, soft reset, steering.
   Bound to hcfb_top below; sees its ports only. */
`timescale 1ns/1ps
module hcfb_top_props #(
    parameter int SRST_CYCLES = 2
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus and link events
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic bus_reset_i,
    // Data path
    input wire logic [3:0] pkt_tcode_i,
    input wire logic pkt_header_i,
    input wire logic [31:0] pkt_data_i,
    input wire logic [31:0] pkt_data_o,
    // Steering outputs
    input wire logic phy_comm_on_o,
    input wire logic bus_attached_o,
    input wire logic fifo_flush_o,
    input wire logic controller_reset_o
);
    import hcfb_pkg::*;
    logic hard_ff;
    logic [7:0] cnt_ff;
    // Marks a hard reset until the reset output drops
    always_ff @(posedge clk_i) begin
        hard_ff <= rst_i | (hard_ff & controller_reset_o);
    end
    // Counts cycles of the reset output
    always_ff @(posedge clk_i) begin
        cnt_ff <= controller_reset_o ? cnt_ff + 8'h01 : 8'h00;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_bus_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
        else $error("request unanswered");
    chk_lps_hold: assert property (
        $fell(phy_comm_on_o) |-> $past(controller_reset_o) || $past(controller_reset_o, 2))
        else $error("power flag dropped");
    chk_attach_hold: assert property (
        $fell(bus_attached_o) |-> $past(controller_reset_o) || $past(controller_reset_o, 2)
            || bus_reset_i || $past(bus_reset_i) || $past(bus_reset_i, 2))
        else $error("attach flag dropped");
    chk_srst_start: assert property (
        wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == HCFB_SET_OFS
            && wb_dat_i[HCFB_SRST_BIT] && !wb_ack_o |-> ##[1:2] controller_reset_o)
        else $error("soft reset not started");
    // Reset output spans the request cycle plus the busy flag's SRST_CYCLES+1
    chk_srst_len: assert property (
        $fell(controller_reset_o) && !hard_ff |-> cnt_ff == SRST_CYCLES + 2)
        else $error("soft reset length wrong");
    chk_hdr_keep: assert property (
        !$past(rst_i) && $past(pkt_header_i) |-> pkt_data_o == $past(pkt_data_i))
        else $error("header quadlet altered");
    chk_phy_keep: assert property (
        !$past(rst_i) && $past(pkt_tcode_i) == HCFB_TC_PHY |-> pkt_data_o == $past(pkt_data_i))
        else $error("phy quadlet altered");
    chk_flush_span: assert property (fifo_flush_o == controller_reset_o)
        else $error("flush and reset differ");
endmodule

bind hcfb_top hcfb_top_props #(.SRST_CYCLES(SRST_CYCLES)) props_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .bus_reset_i(bus_reset_i), .pkt_tcode_i(pkt_tcode_i),
    .pkt_header_i(pkt_header_i), .pkt_data_i(pkt_data_i), .pkt_data_o(pkt_data_o),
    .phy_comm_on_o(phy_comm_on_o), .bus_attached_o(bus_attached_o),
    .fifo_flush_o(fifo_flush_o),
    .controller_reset_o(controller_reset_o)
);

/* verification/hcfb_phy_model.sv */
/* Far-side model: offers a quadlet each cycle, tcodes in turn, random data.
   Assumes the bench notes expectations from valid_o. */
`timescale 1ns/1ps
module hcfb_phy_model (
    // Clock and enable
    input wire logic clk_i,
    input wire logic en_i,
    // Quadlet toward the block
    output logic [3:0] tcode_o,
    output logic header_o,
    output logic ctime_o,
    output logic [31:0] data_o,
    output logic valid_o
);
    integer seed = 32'h0000_669e;
    // Known levels at time zero
    initial begin
        tcode_o = 4'h0;
        header_o = 1'b0;
        ctime_o = 1'b0;
        data_o = 32'h0000_0000;
        valid_o = 1'b0;
    end
    // New data every cycle, so idle lines never rest on an old value
    always @(posedge clk_i) begin
        tcode_o <= tcode_o + 4'h1;
        header_o <= ($random(seed) & 7) == 0;
        ctime_o <= ($random(seed) & 7) == 0;
        data_o <= $random(seed);
        valid_o <= en_i;
    end
endmodule

/* verification/hcfb_top_tb.sv */
/* Bench for hcfb_top: register traffic, soft reset and quadlet steering.
   Assumes the bound checker and the far-side model beside it. */
`timescale 1ns/1ps
`define CHK(e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t exp %h got %h", $time, e, a); end end
module hcfb_top_tb;
    import hcfb_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, brst = 1'b0;
    logic en = 1'b0, big = 1'b0, pv_d = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, ep;
    logic [32:0] ew;
    logic [32:0] wq[$];
    logic [31:0] pq[$];
    int bad_count = 0, checks_done = 0, cycles = 0;
    wire logic ack, err, hdr, ct, pv;
    wire logic [3:0] tc;
    wire logic [31:0] rdat, pdi, pdo;
    // Clock
    always #4 clk_i = ~clk_i;
    hcfb_top #(.SRST_CYCLES(6)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .bus_reset_i(brst), .pkt_tcode_i(tc), .pkt_header_i(hdr),
        .pkt_cycle_time_i(ct), .pkt_data_i(pdi), .pkt_data_o(pdo), .phy_enhance_o(),
        .phy_comm_on_o(), .bus_attached_o(), .write_posted_o(), .fifo_flush_o(),
        .controller_reset_o()
    );
    hcfb_phy_model phy_u (.clk_i(clk_i), .en_i(en), .tcode_o(tc), .header_o(hdr),
        .ctime_o(ct), .data_o(pdi), .valid_o(pv));
    // Expected quadlet after byte-order steering
    function automatic logic [31:0] steer(input logic [3:0] t, input logic h, c,
        input logic [31:0] d);
        if (big || h || c || !(t inside {4'h0, 4'h1, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB}))
            return d;
        return {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction
    // Notes each offered quadlet, compares it a cycle after the block took it
    always @(posedge clk_i) begin
        if (pv_d) begin
            ep = pq.pop_front();
            `CHK(ep, pdo)
        end
        pv_d <= pv;
        if (pv)
            pq.push_back(steer(tc, hdr, ct, pdi));
    end
    // Compares each bus answer with the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 || err === 1'b1) begin
            ew = wq.pop_front();
            `CHK(ew, {err, (we | err) ? 32'h0 : rdat})
        end
    end
    // Classic single cycle; only the timeout bounds the wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d, input logic [32:0] e);
        @(posedge clk_i);
        wq.push_back(e);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
        cyc <= 1'b0;
    endtask
    // Quadlets flow for n cycles, then drain
    task automatic run(input int n);
        en <= 1'b1;
        repeat (n) @(posedge clk_i);
        en <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic summarize();
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            summarize();
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        run(64);
        bus(0, HCFB_SET_OFS, 4'hF, 32'h0, 33'h0_0080_0000);
        bus(1, HCFB_SET_OFS, 4'hF, 32'h0008_0000, 33'h0);
        bus(1, HCFB_SET_OFS, 4'h3, 32'h0040_0000, 33'h0);
        bus(0, HCFB_CLR_OFS, 4'hF, 32'h0, 33'h0_0088_0000);
        bus(1, HCFB_SET_OFS, 4'hF, 32'h4044_0000, 33'h0);
        big <= 1'b1;
        bus(1, HCFB_SET_OFS, 4'hF, 32'h0002_0000, 33'h0);
        brst <= 1'b1;
        repeat (4) @(posedge clk_i);
        brst <= 1'b0;
        bus(0, HCFB_SET_OFS, 4'hF, 32'h0, 33'h0_40CE_0000);
        bus(0, HCFB_STAT_OFS, 4'hF, 32'h0, 33'h0_0000_000F);
        bus(1, HCFB_CLR_OFS, 4'hF, 32'h0082_0000, 33'h0);
        bus(0, HCFB_CLR_OFS, 4'hF, 32'h0, 33'h0_404E_0000);
        bus(1, HCFB_STAT_OFS, 4'hF, 32'h0, 33'h1_0000_0000);
        bus(0, 8'h5C, 4'hF, 32'h0, 33'h1_0000_0000);
        run(64);
        bus(1, HCFB_SET_OFS, 4'hF, 32'h0001_0000, 33'h0);
        bus(0, HCFB_SET_OFS, 4'hF, 32'h0, 33'h0_0041_0000);
        big <= 1'b0;
        repeat (12) @(posedge clk_i);
        bus(0, HCFB_SET_OFS, 4'hF, 32'h0, 33'h0_0040_0000);
        run(64);
        summarize();
    end
endmodule
